/* src/lcc_pkg.sv */
package lcc_pkg;
  localparam logic [7:0] LCC_OFFSET = 8'h00;
  localparam int MODE_BIT = 0;
  localparam int RSV1_BIT = 1;
  localparam int CLK_EN_BIT = 2;
  localparam int LANE_LSB = 3;
  localparam int FILT_LSB = 5;
  localparam int WAKE_EN_BIT = 7;
  localparam int TEST_LSB = 8;
  localparam int EEPROM_SERIAL_CLOCK_PIN_BIT = 24;
  localparam int EEPROM_SELECT_PIN_BIT = 25;
  localparam int EEPROM_WRITE_DATA_PIN_BIT = 26;
  localparam int EEPROM_READ_DATA_PIN_BIT = 27;
  localparam int EE_VALID_BIT = 28;
  localparam int RELOAD_BIT = 29;
  localparam int OVERRUN_BIT = 30;
  localparam int RSV31_BIT = 31;
  localparam logic [5:0] CFG_RESET = 6'h00;
  localparam logic [1:0] FILT_OFF = 2'b00;
  localparam logic [1:0] FILT_4S = 2'b01;
  localparam logic [1:0] FILT_129S = 2'b10;
  localparam logic [1:0] FILT_518S = 2'b11;
  localparam longint CLK_HZ = 50000000;
  localparam longint T4_S = 4;
  localparam longint T129_S = 129;
  localparam longint T518_S = 518;
  localparam logic [35:0] CYC_4S = 36'(T4_S * CLK_HZ);
  localparam logic [35:0] CYC_129S = 36'(T129_S * CLK_HZ);
  localparam logic [35:0] CYC_518S = 36'(T518_S * CLK_HZ);
endpackage

/* src/lcc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Bit 0 reads synchronised mode pin
// - Test bits 23:8 read zero
// - Bit 2 gates serial clock mirror
// - Bits 4:3 select byte lane
// - Bits 6:5 pick power-down filter time
// - Interrupt only if request survives filter
// - Bit 7 lets pin two set wake
// - Bit 24 write-only, drives EEPROM clock
// - Bit 25 drives EEPROM select pin
// - Bit 26 drives EEPROM data pin
// - Bit 27 reads EEPROM data pin
// - Bit 28 reads EEPROM valid
// - Bit 29 starts reload, self-clears
// - Bit 30 reads overrun flag
// - Byte enables allow byte/word/dword writes
module lcc_top #(
  parameter logic [35:0] P_CYC_4S = lcc_pkg::CYC_4S,
  parameter logic [35:0] P_CYC_129S = lcc_pkg::CYC_129S,
  parameter logic [35:0] P_CYC_518S = lcc_pkg::CYC_518S
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_be,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  input wire logic i_mode_pin,
  input wire logic i_serial_ref_clk,
  output logic o_clk_mirror,
  output logic [1:0] o_byte_lane,
  input wire logic i_pd_request,
  output logic o_pd_irq,
  input wire logic i_multipurpose_pin_two,
  output logic o_pin_two_pme_set,
  output logic o_eeprom_serial_clock_pin,
  output logic o_eeprom_select_pin,
  output logic o_eeprom_write_data_pin,
  input wire logic i_eeprom_read_data_pin,
  input wire logic i_ee_load_valid,
  input wire logic [5:0] i_ee_load_data,
  input wire logic i_ee_done,
  input wire logic i_ee_prog_valid,
  input wire logic i_ee_overrun,
  output logic o_ee_reload_req
);
  import lcc_pkg::*;

  logic [2:0] mode_sy_ff, clk_sy_ff, di_sy_ff, pin2_sy_ff;
  logic mode_ff, clk_ff, di_ff, pin2_ff;
  logic [5:0] cfg_ff;
  logic ck_ff, cs_ff, do_ff, reload_ff, valid_ff, ovr_ff;
  logic [35:0] pd_cnt_ff;
  logic pd_irq_ff, mirror_ff, pme_ff;
  logic [31:0] rdata_ff;

  // Three-stage sync; value changes only when stages two and three agree
  always_ff @(posedge i_clk_sys) begin
    mode_sy_ff <= {mode_sy_ff[1:0], i_mode_pin};
    clk_sy_ff <= {clk_sy_ff[1:0], i_serial_ref_clk};
    di_sy_ff <= {di_sy_ff[1:0], i_eeprom_read_data_pin};
    pin2_sy_ff <= {pin2_sy_ff[1:0], i_multipurpose_pin_two};
  end

  wire mode_agree = mode_sy_ff[1] == mode_sy_ff[2];
  wire clk_agree = clk_sy_ff[1] == clk_sy_ff[2];
  wire di_agree = di_sy_ff[1] == di_sy_ff[2];
  wire pin2_agree = pin2_sy_ff[1] == pin2_sy_ff[2];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mode_ff <= 1'b0;
      clk_ff <= 1'b0;
      di_ff <= 1'b0;
      pin2_ff <= 1'b0;
    end else begin
      if (mode_agree) mode_ff <= mode_sy_ff[2];
      if (clk_agree) clk_ff <= clk_sy_ff[2];
      if (di_agree) di_ff <= di_sy_ff[2];
      if (pin2_agree) pin2_ff <= pin2_sy_ff[2];
    end
  end

  // Byte-enable write strobes; only memory space can carry wider accesses
  wire wr_b0 = i_reg_wr & i_reg_be[0];
  wire wr_b3 = i_reg_wr & i_reg_be[3];

  // PCI write wins over a simultaneous EEPROM download
  wire [5:0] nxt_cfg = wr_b0 ? i_reg_wdata[WAKE_EN_BIT:CLK_EN_BIT] :
                       i_ee_load_valid ? i_ee_load_data : cfg_ff;
  // A fresh reload write wins over a same-cycle done, so no request is lost
  wire nxt_reload = (wr_b3 & i_reg_wdata[RELOAD_BIT]) ? 1'b1 :
                    i_ee_done ? 1'b0 : reload_ff;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cfg_ff <= CFG_RESET;
      ck_ff <= 1'b0;
      cs_ff <= 1'b0;
      do_ff <= 1'b0;
      reload_ff <= 1'b0;
      valid_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      if (wr_b3) begin
        ck_ff <= i_reg_wdata[EEPROM_SERIAL_CLOCK_PIN_BIT];
        cs_ff <= i_reg_wdata[EEPROM_SELECT_PIN_BIT];
        do_ff <= i_reg_wdata[EEPROM_WRITE_DATA_PIN_BIT];
      end
      reload_ff <= nxt_reload;
      if (i_ee_done) begin
        valid_ff <= i_ee_prog_valid;
        ovr_ff <= i_ee_overrun;
      end
    end
  end

  wire [1:0] filt_sel = cfg_ff[FILT_LSB-CLK_EN_BIT +: 2];
  wire [35:0] filt_cyc = (filt_sel == FILT_4S) ? P_CYC_4S :
                         (filt_sel == FILT_129S) ? P_CYC_129S : P_CYC_518S;
  wire pd_armed = (filt_sel != FILT_OFF) & i_pd_request;
  wire pd_done = pd_cnt_ff >= filt_cyc;

  // Counter restarts whenever the request drops, so only a held request fires
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pd_cnt_ff <= 36'h0_0000_0000;
      pd_irq_ff <= 1'b0;
    end else begin
      pd_cnt_ff <= !pd_armed ? 36'h0_0000_0000 :
                   pd_done ? pd_cnt_ff : pd_cnt_ff + 36'h0_0000_0001;
      pd_irq_ff <= pd_armed & pd_done;
    end
  end

  wire wake_en = cfg_ff[WAKE_EN_BIT-CLK_EN_BIT];
  wire clk_en = cfg_ff[0];
  // Mirror is a resampled copy; fine detail of the source clock is lost
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mirror_ff <= 1'b0;
      pme_ff <= 1'b0;
    end else begin
      mirror_ff <= clk_en & clk_ff;
      pme_ff <= wake_en & pin2_ff;
    end
  end

  // Write-only bits 29 and 26:24 read as zero
  wire [31:0] rd_word = {1'b1, ovr_ff, 1'b0, valid_ff, di_ff, 3'h0, 16'h0000, cfg_ff,
                         1'b0, mode_ff};
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      rdata_ff <= rd_word;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_clk_mirror = mirror_ff;
  assign o_byte_lane = cfg_ff[LANE_LSB-CLK_EN_BIT +: 2];
  assign o_pd_irq = pd_irq_ff;
  assign o_pin_two_pme_set = pme_ff;
  assign o_eeprom_serial_clock_pin = ck_ff;
  assign o_eeprom_select_pin = cs_ff;
  assign o_eeprom_write_data_pin = do_ff;
  assign o_ee_reload_req = reload_ff;

  a_clk_gated: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !$past(clk_en) |-> !o_clk_mirror) else $error("mirror not low");
  a_cs_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_b3 |=> o_eeprom_select_pin == $past(i_reg_wdata[EEPROM_SELECT_PIN_BIT]))
    else $error("select pin wrong");
  a_do_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_b3 |=> o_eeprom_write_data_pin == $past(i_reg_wdata[EEPROM_WRITE_DATA_PIN_BIT]))
    else $error("data pin wrong");
  a_reload_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (wr_b3 && i_reg_wdata[RELOAD_BIT]) |=> o_ee_reload_req)
    else $error("reload not set");
  a_reload_clr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ee_done && !(wr_b3 && i_reg_wdata[RELOAD_BIT])) |=> !o_ee_reload_req)
    else $error("reload not cleared");
  a_read_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(i_reg_rd) |-> (o_reg_rdata[31] && !o_reg_rdata[1] && o_reg_rdata[23:8] == 16'h0000
    && o_reg_rdata[24] == 1'b0)) else $error("fixed bits wrong");
  a_pd_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (filt_sel == FILT_OFF) [*2] |-> !o_pd_irq) else $error("irq while disabled");
  a_pd_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_pd_request |=> !o_pd_irq) else $error("irq without request");
  a_wake_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !$past(wake_en) |-> !o_pin_two_pme_set) else $error("wake while off");
  a_cfg_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_b0 |=> o_byte_lane == $past(i_reg_wdata[4:3])) else $error("lane not written");

  a_ck_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_b3 |=> o_eeprom_serial_clock_pin == $past(i_reg_wdata[EEPROM_SERIAL_CLOCK_PIN_BIT]))
    else $error("clock pin wrong");
  a_ck_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !wr_b3 |=> $stable(o_eeprom_serial_clock_pin)) else $error("clock pin moved");
  a_cs_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !wr_b3 |=> $stable(o_eeprom_select_pin)) else $error("select pin moved");
  a_do_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !wr_b3 |=> $stable(o_eeprom_write_data_pin)) else $error("data pin moved");

  a_mode_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_reg_rd |=> o_reg_rdata[MODE_BIT] == $past(mode_ff)) else $error("mode bit wrong");
  a_di_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_reg_rd |=> o_reg_rdata[EEPROM_READ_DATA_PIN_BIT] == $past(di_ff)) else $error("data in wrong");
  a_valid_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_reg_rd |=> o_reg_rdata[EE_VALID_BIT] == $past(valid_ff))
    else $error("valid bit wrong");
  a_ovr_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_reg_rd |=> o_reg_rdata[OVERRUN_BIT] == $past(ovr_ff))
    else $error("overrun bit wrong");
  a_cfg_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_reg_rd |=> o_reg_rdata[WAKE_EN_BIT:CLK_EN_BIT] == $past(cfg_ff))
    else $error("config bits wrong");
  a_wo_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_reg_rd |=> (!o_reg_rdata[RELOAD_BIT] && o_reg_rdata[EEPROM_WRITE_DATA_PIN_BIT:EEPROM_SERIAL_CLOCK_PIN_BIT] == 3'h0))
    else $error("write-only bits read");
  a_rdata_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");

  a_valid_cap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ee_done |=> valid_ff == $past(i_ee_prog_valid)) else $error("valid not taken");
  a_ovr_cap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ee_done |=> ovr_ff == $past(i_ee_overrun)) else $error("overrun not taken");
  a_status_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_ee_done |=> ($stable(valid_ff) && $stable(ovr_ff))) else $error("status moved");
  a_reload_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!(wr_b3 && i_reg_wdata[RELOAD_BIT]) && !i_ee_done) |=> $stable(o_ee_reload_req))
    else $error("reload moved");

  a_load_cfg: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ee_load_valid && !wr_b0) |=> cfg_ff == $past(i_ee_load_data))
    else $error("load not taken");
  a_cfg_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!wr_b0 && !i_ee_load_valid) |=> $stable(cfg_ff)) else $error("config moved");

  a_mirror_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    clk_en |=> o_clk_mirror == $past(clk_ff)) else $error("mirror not copying");
  a_pme_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wake_en |=> o_pin_two_pme_set == $past(pin2_ff)) else $error("wake not passed");

  a_pd_wait: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (pd_armed && !pd_done) |=> !o_pd_irq) else $error("irq too early");
  a_pd_fire: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (pd_armed && pd_done) |=> o_pd_irq) else $error("irq missing");
  a_cnt_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !pd_armed |=> pd_cnt_ff == 36'h0_0000_0000) else $error("counter not cleared");
  a_cnt_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (pd_armed && !pd_done) |=> pd_cnt_ff == $past(pd_cnt_ff) + 36'h0_0000_0001)
    else $error("counter not stepping");
  a_cnt_sat: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (pd_armed && pd_done) |=> pd_cnt_ff == $past(pd_cnt_ff))
    else $error("counter ran past end");

  a_mode_sync: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_agree |=> mode_ff == $past(mode_sy_ff[2])) else $error("mode not taken");
  a_mode_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !mode_agree |=> $stable(mode_ff)) else $error("mode took glitch");
  a_di_sync: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    di_agree |=> di_ff == $past(di_sy_ff[2])) else $error("data in not taken");
  a_di_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !di_agree |=> $stable(di_ff)) else $error("data in took glitch");
  a_clk_sync: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    clk_agree |=> clk_ff == $past(clk_sy_ff[2])) else $error("ref clock not taken");
  a_clk_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !clk_agree |=> $stable(clk_ff)) else $error("ref clock took glitch");
  a_pin2_sync: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    pin2_agree |=> pin2_ff == $past(pin2_sy_ff[2])) else $error("pin two not taken");
  a_pin2_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !pin2_agree |=> $stable(pin2_ff)) else $error("pin two took glitch");
endmodule // lcc_top
`default_nettype wire

/* bench/lcc_ee_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lcc_ee_model (
  input wire logic i_clk_sys,
  input wire logic i_sclk,
  input wire logic i_cs,
  output logic o_dout
);
  logic [3:0] pat_ff = 4'hA;
  logic sclk_q = 1'b0;
  initial o_dout = 1'b0;
  // Deselected line wanders every cycle so a stale level cannot pass
  // Clock rise is sampled, so select and clock landing together is no race
  always @(posedge i_clk_sys) begin
    sclk_q <= i_sclk;
    if (!i_cs) o_dout <= ~o_dout;
    else if (i_sclk && !sclk_q) begin
      o_dout <= pat_ff[3];
      pat_ff <= {pat_ff[2:0], pat_ff[3]};
    end
  end
endmodule // lcc_ee_model
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, mode = 1, ref_ck = 0, pdr = 0, pin2 = 1;
  logic ldv = 0, done = 0, pv = 0, ov = 0, sclk, cs, dout, din, irq, pme, mir, rq;
  logic [3:0] be = 0;
  logic [31:0] wd = 0, rdat;
  logic [1:0] lane;
  logic [5:0] ldd = 0;
  int n_errors = 0, samples_checked = 0, cyc = 0, mir_rises = 0, snap = 0;
  logic mir_q = 0;
  always @(posedge clk) begin
    mir_q <= mir;
    if (mir && !mir_q) mir_rises++;
  end
  always #10 clk = ~clk;
  always #37 ref_ck = ~ref_ck;
  // Short filter counts keep the power-down test to a few dozen cycles
  lcc_top #(.P_CYC_4S(36'h0_0000_0014), .P_CYC_129S(36'h0_0000_0028),
    .P_CYC_518S(36'h0_0000_003C)) i_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_be(be),
    .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_mode_pin(mode), .i_serial_ref_clk(ref_ck),
    .o_clk_mirror(mir), .o_byte_lane(lane), .i_pd_request(pdr), .o_pd_irq(irq),
    .i_multipurpose_pin_two(pin2), .o_pin_two_pme_set(pme), .o_eeprom_serial_clock_pin(sclk),
    .o_eeprom_select_pin(cs), .o_eeprom_write_data_pin(dout), .i_eeprom_read_data_pin(din),
    .i_ee_load_valid(ldv), .i_ee_load_data(ldd), .i_ee_done(done), .i_ee_prog_valid(pv),
    .i_ee_overrun(ov), .o_ee_reload_req(rq));
  lcc_ee_model i_ee (.i_clk_sys(clk), .i_sclk(sclk), .i_cs(cs), .o_dout(din));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    samples_checked++;
    if ((got & mask) !== (exp & mask)) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] b, input logic [31:0] d);
    @(posedge clk) begin
      wr <= 1;
      be <= b;
      wd <= d;
    end
    @(posedge clk) wr <= 0;
  endtask
  task automatic rd_reg(input logic [31:0] exp, input logic [31:0] mask);
    @(posedge clk) rd <= 1;
    @(posedge clk) rd <= 0;
    @(posedge clk) #1 chk(rdat, exp, mask);
  endtask
  task automatic give_verdict();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (6) @(posedge clk);
    rd_reg(32'h8000_0001, 32'hC0FF_FFFF);
    chk(32'(mir_rises), 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test reset done");
    wr_reg(4'hF, 32'hFF00_00FF);
    repeat (6) @(posedge clk);
    chk(32'({lane, cs, sclk, dout, rq, pme}), 32'h0000_007F, 32'h0000_007F);
    rd_reg(32'h8000_00FD, 32'hC0FF_FFFF);
    @(posedge clk) begin
      done <= 1;
      pv <= 1;
      ov <= 1;
    end
    @(posedge clk) done <= 0;
    @(posedge clk) #1 chk(32'(rq), 32'h0000_0000, 32'h0000_0001);
    rd_reg(32'h5000_0000, 32'h7000_0000);
    $display("test eeprom status done");
    @(posedge clk) begin
      ldv <= 1;
      ldd <= 6'h15;
    end
    @(posedge clk) ldv <= 0;
    rd_reg(32'h0000_0055, 32'h0000_00FF);
    wr_reg(4'h1, 32'h0000_0024);
    @(posedge clk) pdr <= 1;
    repeat (15) @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0000, 32'h0000_0001);
    repeat (10) @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0001, 32'h0000_0001);
    @(posedge clk) pdr <= 0;
    repeat (3) @(posedge clk);
    #1 chk(32'(irq), 32'h0000_0000, 32'h0000_0001);
    $display("test power down done");
    // Select stays high, so each clock rise shifts the next model bit out
    for (int k = 0; k < 2; k++) begin
      wr_reg(4'h8, 32'h0200_0000);
      wr_reg(4'h8, 32'h0300_0000);
      repeat (6) @(posedge clk);
      rd_reg(32'(k) << 27, 32'h0800_0000);
    end
    $display("test eeprom read done");
    chk(32'(mir_rises != 0), 32'h0000_0001, 32'h0000_0001);
    wr_reg(4'h1, 32'h0000_0000);
    repeat (2) @(posedge clk);
    snap = mir_rises;
    repeat (20) @(posedge clk);
    chk(32'(mir_rises - snap), 32'h0000_0000, 32'hFFFF_FFFF);
    @(posedge clk) mode <= 0;
    repeat (6) @(posedge clk);
    rd_reg(32'h8000_0000, 32'h8000_0001);
    $display("test mirror and mode done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
